// ### verilog/adc_compare_trigger_fsm.sv
// Purpose: Trigger generation for one ADC digital comparator.
// Assumes: Conversion results arrive on clk from local logic.
// Notes:   Registers are reached over an AXI4-Lite slave.
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.

`timescale 1ns/1ps

module adc_compare_trigger_fsm
    import adc_cmp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Write address channel.
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output      logic              awready,
    // Write data channel.
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output      logic              wready,
    // Write response channel.
    output      logic [1:0]        bresp,
    output      logic              bvalid,
    input  wire logic              bready,
    // Read address channel.
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output      logic              arready,
    // Read data channel.
    output      logic [31:0]       rdata,
    output      logic [1:0]        rresp,
    output      logic              rvalid,
    input  wire logic              rready,
    // Conversion stream and thresholds.
    input  wire conv_t             conv,
    input  wire logic [CONV_W-1:0] lower_threshold,
    input  wire logic [CONV_W-1:0] upper_threshold,
    // Trigger pulse to the consumer.
    output      logic              trigger
);

    ////////////////////////////////////////////////////////////////////
    // Elaboration check.
    ////////////////////////////////////////////////////////////////////

    // The decoder pads offsets with upper zero bits.
    if (ADDR_W < 5) begin : g_addr_chk
        $error("ADDR_W must be at least 5");
    end

    // Match a bus address against a register offset.
    function automatic logic is_at(input logic [ADDR_W-1:0] a,
                                   input logic [3:0]        off);
        is_at = (a == {{(ADDR_W-4){1'b0}}, off});
    endfunction

    // Known register addresses answer OKAY.
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = is_at(a, CTRL_OFFSET) || is_at(a, SRESET_OFFSET)
                    || is_at(a, STATUS_OFFSET);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Storage.
    ////////////////////////////////////////////////////////////////////

    ctrl_t              ctrl;       // Software control fields.
    logic               reset_req;  // One-cycle state reset request.
    logic               prev_in;    // Previous result was in region.
    hyst_t              hyst;       // Hysteresis state.
    hyst_t              next_hyst;  // Next hysteresis state.
    logic               aw_held;    // Write address captured.
    logic [ADDR_W-1:0]  aw_addr;    // Captured write address.
    logic               w_held;     // Write data captured.
    logic [31:0]        w_data;     // Captured write data.
    logic [3:0]         w_strb;     // Captured byte enables.

    ////////////////////////////////////////////////////////////////////
    // Write path decode.
    ////////////////////////////////////////////////////////////////////

    // A write is done once both halves are in and no answer waits.
    wire do_write  = aw_held && w_held && !bvalid;
    wire wr_ctrl   = do_write && is_at(aw_addr, CTRL_OFFSET) && w_strb[1];
    wire wr_sreset = do_write && is_at(aw_addr, SRESET_OFFSET) && w_strb[0];
    wire wr_resp_ok = is_mapped(aw_addr);

    // Write address capture; held until the response is taken.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            awready <= 1'b1;
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_held <= 1'b1;
            aw_addr <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
            aw_held <= 1'b0;
        end
    end

    // Write data capture; either order against the address.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wready <= 1'b1;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            w_held <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
            w_held <= 1'b0;
        end
    end

    // Write response; unmapped addresses answer SLVERR.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= wr_resp_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control register.
    ////////////////////////////////////////////////////////////////////

    // Fields live in byte lane 1, so only that strobe updates them.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl.enable <= w_data[ENABLE_BIT];
            ctrl.region <= w_data[REGION_LSB +: 2];
            ctrl.mode   <= w_data[MODE_LSB +: 2];
        end
    end

    // State reset request clears itself after one cycle.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reset_req <= 1'b0;
        end else begin
            reset_req <= wr_sreset && w_data[SRESET_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path.
    ////////////////////////////////////////////////////////////////////

    // Bits 7:5 and the upper word are tied to zero.
    wire [31:0] ctrl_word = {19'h0_0000, ctrl.enable, ctrl.region,
                             ctrl.mode, 3'h0, 5'h00};
    wire [31:0] stat_word = {30'h0000_0000, hyst == HY_HELD, prev_in};
    wire [31:0] rd_value  = is_at(araddr, CTRL_OFFSET)   ? ctrl_word :
                            is_at(araddr, STATUS_OFFSET) ? stat_word :
                            32'h0000_0000;

    // One read at a time; arready drops until the data is taken.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_value;
            rresp   <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Region decode.
    ////////////////////////////////////////////////////////////////////

    // The bands assume upper >= lower; software keeps that.
    wire below_both = conv.data < lower_threshold
                      && conv.data < upper_threshold;
    wire mid_band   = conv.data >= lower_threshold
                      && conv.data < upper_threshold;
    wire high_band  = conv.data >= upper_threshold;

    // Reserved region code never counts as in region.
    wire in_region = (ctrl.region == REGION_LOW)  ? below_both :
                     (ctrl.region == REGION_MID)  ? mid_band :
                     (ctrl.region == REGION_HIGH) ? high_band : 1'b0;

    // Mid band has no opposite, so there only a state reset request clears hysteresis.
    wire opposite  = (ctrl.region == REGION_LOW)  ? high_band :
                     (ctrl.region == REGION_HIGH) ? below_both :
                     1'b0;

    // A result is looked at once, and only while enabled.
    wire evaluate  = conv.valid && ctrl.enable;

    // A reset request in the same cycle as a result starts fresh.
    wire   base_prev = reset_req ? 1'b0 : prev_in;
    hyst_t base_hyst;
    assign base_hyst = reset_req ? HY_CLEAR : hyst;
    wire   base_held = (base_hyst == HY_HELD);

    ////////////////////////////////////////////////////////////////////
    // Trigger decision.
    ////////////////////////////////////////////////////////////////////

    logic fire;  // Mode-qualified trigger decision.

    // Each mode turns region membership into a trigger.
    always_comb begin
        case (ctrl.mode)
            MODE_ALWAYS:      fire = in_region;
            MODE_ONCE:        fire = in_region && !base_prev;
            MODE_HYST_ALWAYS: fire = in_region
                                     || (base_held && !opposite);
            MODE_HYST_ONCE:   fire = in_region && !base_held;
            default:          fire = 1'b0;
        endcase
    end

    // Hysteresis arms on region entry and clears on the opposite band.
    always_comb begin
        case (base_hyst)
            HY_CLEAR: next_hyst = (evaluate && ctrl.mode[1] && in_region)
                                  ? HY_HELD : HY_CLEAR;
            HY_HELD:  next_hyst = (evaluate && opposite)
                                  ? HY_CLEAR : HY_HELD;
            default:  next_hyst = HY_CLEAR;
        endcase
    end

    // Held state and the registered one-cycle trigger pulse.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hyst    <= HY_CLEAR;
            prev_in <= 1'b0;
            trigger <= 1'b0;
        end else begin
            hyst    <= next_hyst;
            prev_in <= evaluate ? in_region : base_prev;
            trigger <= evaluate && fire;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions.
    ////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    wire ev_mode0 = evaluate && ctrl.mode == MODE_ALWAYS;

    trig_cause_a: assert property (
        trigger |-> $past(conv.valid) && $past(ctrl.enable))
        else $error("trigger without an enabled result");

    low_band_a: assert property (
        ev_mode0 && ctrl.region == REGION_LOW |=> trigger == $past(below_both))
        else $error("low band decision wrong");

    mid_band_a: assert property (
        ev_mode0 && ctrl.region == REGION_MID |=> trigger == $past(mid_band))
        else $error("mid band decision wrong");

    high_band_a: assert property (
        ev_mode0 && ctrl.region == REGION_HIGH |=> trigger == $past(high_band))
        else $error("high band decision wrong");

    once_repeat_a: assert property (
        evaluate && ctrl.mode == MODE_ONCE && prev_in && !reset_req
        |=> !trigger)
        else $error("once mode retriggered");

    hyst_keep_a: assert property (
        evaluate && ctrl.mode == MODE_HYST_ALWAYS && hyst == HY_HELD
        && !opposite && !reset_req |=> trigger)
        else $error("hysteresis always dropped trigger");

    hyst_once_a: assert property (
        evaluate && ctrl.mode == MODE_HYST_ONCE && hyst == HY_HELD
        && !reset_req |=> !trigger)
        else $error("hysteresis once retriggered");

    opp_clear_a: assert property (
        evaluate && opposite |=> hyst == HY_CLEAR)
        else $error("opposite band did not clear hysteresis");

    state_reset_a: assert property (
        reset_req && !evaluate |=> !prev_in && hyst == HY_CLEAR)
        else $error("state reset did not clear");

    idle_hold_a: assert property (
        !evaluate && !reset_req |=> $stable(prev_in) && !trigger)
        else $error("state moved without a result");

    rsvd_zero_a: assert property (
        rvalid |-> rdata[7:5] == 3'h0)
        else $error("reserved bits read nonzero");

    // Main scenarios.
    hyst_run_c:  cover property (hyst == HY_HELD ##1 trigger ##1 trigger);
    once_hit_c:  cover property (ctrl.mode == MODE_ONCE && trigger);
    write_c:     cover property (bvalid && bready && bresp == RESP_OKAY);
    read_c:      cover property (rvalid && rready && rdata != 32'h0000_0000);

endmodule // adc_compare_trigger_fsm

// ### verilog/adc_cmp_pkg.sv
// Purpose: Constants and types for the ADC compare trigger block.
// Assumes: One system clock, synchronous active-high reset.
// Notes:   Register offsets are byte addresses on the AXI4-Lite slave.
// Operation
// - Enable bit gates all trigger evaluation.
// - Region select field at bits 11:10.
// - Low band: below both thresholds.
// - Mid band: lower <= data < upper.
// - High band: data >= upper; 0x2 reserved.
// - Trigger mode field at bits 9:8.
// - Always mode: trigger every in-region result.
// - Once mode: trigger only on region entry.
// - Hysteresis always: trigger until opposite region.
// - Hysteresis once: one trigger until opposite region.
// - Bits 7:5 read-only, read as zero.
// - Previous-result state cleared by software request.

package adc_cmp_pkg;

    // Conversion result width.
    localparam int CONV_W = 12;

    // Register byte offsets.
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] SRESET_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;

    // Control field positions.
    localparam int ENABLE_BIT = 12;
    localparam int REGION_LSB = 10;
    localparam int MODE_LSB   = 8;
    localparam int SRESET_BIT = 0;

    // Region encodings.
    localparam logic [1:0] REGION_LOW  = 2'h0;
    localparam logic [1:0] REGION_MID  = 2'h1;
    localparam logic [1:0] REGION_HIGH = 2'h3;

    // Mode encodings.
    localparam logic [1:0] MODE_ALWAYS      = 2'h0;
    localparam logic [1:0] MODE_ONCE        = 2'h1;
    localparam logic [1:0] MODE_HYST_ALWAYS = 2'h2;
    localparam logic [1:0] MODE_HYST_ONCE   = 2'h3;

    // Bus response codes.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One conversion result with its strobe.
    typedef struct packed {
        logic              valid;
        logic [CONV_W-1:0] data;
    } conv_t;

    // Software control fields.
    typedef struct packed {
        logic       enable;
        logic [1:0] region;
        logic [1:0] mode;
    } ctrl_t;

    // Reset value of the control fields.
    localparam ctrl_t CTRL_RESET = '{1'b0, 2'h0, 2'h0};

    // Hysteresis state.
    typedef enum logic {
        HY_CLEAR = 1'b0,
        HY_HELD  = 1'b1
    } hyst_t;

endpackage

// ### testbench/adc_stream_model.sv
// Purpose: Conversion-result source and trigger consumer for the compare bench.
// Assumes: The caller invokes put right after a rising edge of clk.
// Notes:   Between results the data lines show the inverse of the last value.

`timescale 1ns/1ps

module adc_stream_model
    import adc_cmp_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic sys_rst,
    // Trigger pulse from the comparator.
    input  wire logic trigger,
    // Conversion stream toward the comparator.
    output conv_t     conv,
    output int        pulse_count
);

    ////////////////////////////////////////////////////////////////////////////////
    // Stream source.

    // The stream starts idle so no result is seen during reset.
    initial begin
        conv = '0;
    end

    // One result per call, so at most one result per cycle.
    // Idle data is inverted so a stale value never looks like a fresh result.
    task automatic put(input logic v, input logic [CONV_W-1:0] d);
        conv.valid <= v;
        conv.data  <= v ? d : ~conv.data;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger consumer.

    // Counts pulses; a pulse that stretches would be counted twice.
    always @(posedge clk) begin
        if (sys_rst) begin
            pulse_count <= 0;
        end else if (trigger === 1'b1) begin
            pulse_count <= pulse_count + 1;
        end
    end

endmodule // adc_stream_model

// ### testbench/testbench.sv
// Purpose: Self-checking bench for the compare trigger block.
// Assumes: The model drives results; the bench owns the register bus.
// Notes:   Expected triggers come from a small reference of the band rules.

`timescale 1ns/1ps

`define CHECK(name, exp, got) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected %s: expected %h, seen %h", name, exp, got); end end

module testbench
    import adc_cmp_pkg::*;
;
    // Design ports.
    logic              clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
    logic              awready, wready, bvalid, arready, rvalid, trigger;
    logic [7:0]        awaddr, araddr;
    logic [31:0]       wdata, rdata, rdv;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, rs;
    conv_t             conv;
    logic [CONV_W-1:0] lower_threshold, upper_threshold;
    // Reference state and bookkeeping.
    logic              en, pend, prev, held;
    logic [1:0]        region, mode;
    int                mismatches, n_tests, exp_pulses, pulse_count;
    logic [11:0]       seq [14] = '{12'h032, 12'h03C, 12'h096, 12'h0FA, 12'h104, 12'h096,
        12'h032, 12'h028, 12'h0FA, 12'h0FA, 12'h064, 12'h0C7, 12'h0C8, 12'h063};
    logic [1:0]        regions [3] = '{REGION_LOW, REGION_MID, REGION_HIGH};

    adc_compare_trigger_fsm DUT (.clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .conv, .lower_threshold, .upper_threshold, .trigger);

    adc_stream_model model (.clk, .sys_rst, .trigger, .conv, .pulse_count);

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, verdict and watchdog.

    // 100 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Single exit point of the run.
    task automatic finish_test;
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // The whole sequence needs a few hundred cycles; this is ample margin.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus and stream tasks.

    // Address and data are offered together; bready stays up until bvalid is seen.
    task automatic axi_wr(input logic [3:0] off, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        awaddr <= {4'h0, off};
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask

    // Read one word; data and response are taken at the rvalid edge.
    task automatic axi_rd(input logic [3:0] off);
        @(posedge clk);
        araddr <= {4'h0, off};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rdv = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // Reference decision; hysteresis is only ever set in modes 2 and 3.
    task automatic predict(input logic v, input logic [11:0] d);
        logic in_r, opp;
        in_r = (region == REGION_LOW) ? (d < lower_threshold && d < upper_threshold) :
               (region == REGION_MID) ? (d >= lower_threshold && d < upper_threshold) :
               (region == REGION_HIGH) ? (d >= upper_threshold) : 1'b0;
        opp = (region == REGION_LOW) ? (d >= upper_threshold) :
              (region == REGION_HIGH) ? (d < lower_threshold && d < upper_threshold) : 1'b0;
        pend = 1'b0;
        if (v && en) begin
            case (mode)
                MODE_ALWAYS:      pend = in_r;
                MODE_ONCE:        pend = in_r && !prev;
                MODE_HYST_ALWAYS: pend = in_r || (held && !opp);
                default:          pend = in_r && !held;
            endcase
            if (mode[1] && in_r) held = 1'b1;
            else if (opp) held = 1'b0;
            prev = in_r;
        end
        if (pend) exp_pulses++;
    endtask

    // Launch one result and check the pulse owed by the previous one.
    task automatic step(input logic v, input logic [11:0] d);
        @(posedge clk);
        model.put(v, d);
        @(negedge clk);
        `CHECK("trigger", pend, trigger)
        predict(v, d);
    endtask

    // Program the control fields and mirror them in the reference.
    task automatic cfg(input logic e, input logic [1:0] g, input logic [1:0] m);
        en = e;
        region = g;
        mode = m;
        axi_wr(CTRL_OFFSET, {19'h0, e, g, m, 8'h00}, 4'hF);
        `CHECK("ctrl bresp", RESP_OKAY, rs)
    endtask

    // Clear the held state in the design and in the reference.
    task automatic clear_state;
        axi_wr(SRESET_OFFSET, 32'h0000_0001, 4'h1);
        prev = 1'b0;
        held = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence.

    initial begin
        sys_rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {en, pend, prev, held, region, mode} = '0;
        mismatches = 0;
        n_tests = 0;
        exp_pulses = 0;
        lower_threshold = 12'h064;  // Upper kept above lower
        upper_threshold = 12'h0C8;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        axi_rd(CTRL_OFFSET);
        `CHECK("ctrl reset", 32'h0000_0000, rdv)
        axi_rd(STATUS_OFFSET);
        `CHECK("status reset", 32'h0000_0000, rdv)
        cfg(1'b1, REGION_HIGH, MODE_HYST_ONCE);
        axi_wr(CTRL_OFFSET, 32'hFFFF_FFFF, 4'hF);
        axi_rd(CTRL_OFFSET);
        `CHECK("ctrl all ones", 32'h0000_1F00, rdv)
        axi_wr(CTRL_OFFSET, 32'h0000_0000, 4'h1);
        axi_rd(CTRL_OFFSET);
        `CHECK("ctrl low lane", 32'h0000_1F00, rdv)
        axi_wr(4'hC, 32'h0000_1F00, 4'hF);
        `CHECK("unmapped bresp", RESP_SLVERR, rs)
        axi_rd(4'hC);
        `CHECK("unmapped rresp", RESP_SLVERR, rs)
        axi_rd(SRESET_OFFSET);
        `CHECK("sreset read", 32'h0000_0000, rdv)
        // Every region with every mode; hysteresis is never paired with mid band.
        foreach (regions[r]) begin
            for (int m = 0; m < 4; m++) begin
                if (regions[r] == REGION_MID && m >= 2) continue;
                cfg(1'b1, regions[r], 2'(m));
                clear_state;
                foreach (seq[i]) begin
                    step(1'b1, seq[i]);
                    if (i == 6) step(1'b0, 12'h000);
                end
                step(1'b0, 12'h000);
                axi_rd(STATUS_OFFSET);
                `CHECK("status", {30'h0, held, prev}, rdv)
            end
        end
        // Disabled results must leave the once state untouched.
        clear_state;
        cfg(1'b0, REGION_LOW, MODE_ONCE);
        step(1'b1, 12'h032);
        step(1'b1, 12'h032);
        step(1'b0, 12'h000);
        cfg(1'b1, REGION_LOW, MODE_ONCE);
        step(1'b1, 12'h032);
        step(1'b1, 12'h032);
        step(1'b0, 12'h000);
        `CHECK("pulse count", exp_pulses, pulse_count)
        finish_test;
    end

endmodule // testbench
